// >>> rtl/rlsb_rx_lane_status.v
// Purpose: per-lane word lock, meta word checks and raw lane word read port
// Assumes: lane words arrive already gearboxed, synchronous to i_clk_sys
// Notes: each lane buffers up to eight words; source stalls on ready low
`timescale 1ns/1ps
`include "rlsb_map.vh"
`default_nettype none
module rlsb_rx_lane_status #(
    parameter LANES = `RLSB_LANES,
    parameter WW = `RLSB_WORD_W,
    parameter DEPTH = `RLSB_FIFO_DEPTH,
    parameter AW = `RLSB_FIFO_AW,
    parameter MUW = `RLSB_MU_W
) (
    input wire i_clk_sys,
    input wire i_rst,
    // incoming lane words, lane l at bits l*WW +: WW
    input wire [LANES*WW-1:0] i_rx_lane_word,
    input wire [LANES-1:0] i_rx_lane_word_valid,
    output wire [LANES-1:0] o_rx_lane_word_ready,
    // status
    output reg [LANES-1:0] o_rx_bad_type_err,
    output reg [LANES-1:0] o_rx_word_lock,
    output reg [MUW-1:0] o_rx_multiuse_control_bits,
    output reg o_rx_multiuse_bits_changed_pulse,
    // raw read port
    input wire i_raw_rx_read_request,
    input wire i_raw_rx_force_resync,
    output wire [LANES-1:0] o_raw_rx_lane_word_available,
    output reg [LANES-1:0] o_raw_rx_lane_word_valid,
    output reg [LANES-1:0] o_raw_rx_framing_word_flag,
    output reg [LANES-1:0] o_raw_rx_bad_framing_flag,
    output wire [WW-1:0] o_raw_rx_lane0_word,
    output wire [WW-1:0] o_raw_rx_lane1_word,
    output wire [WW-1:0] o_raw_rx_lane2_word,
    output wire [WW-1:0] o_raw_rx_lane3_word,
    output wire [WW-1:0] o_raw_rx_lane4_word,
    output wire [WW-1:0] o_raw_rx_lane5_word,
    output wire [WW-1:0] o_raw_rx_lane6_word,
    output wire [WW-1:0] o_raw_rx_lane7_word,
    output wire [WW-1:0] o_raw_rx_lane8_word,
    output wire [WW-1:0] o_raw_rx_lane9_word,
    output wire [WW-1:0] o_raw_rx_lane10_word,
    output wire [WW-1:0] o_raw_rx_lane11_word
);
    localparam BW = WW + 2;
    localparam CW = `RLSB_LOCK_CW;

    ////////////////////////////////////////////////////////////////////////
    // shared signals

    reg [LANES*WW-1:0] out_word_r;
    wire [LANES-1:0] frm_ok;
    wire [LANES-1:0] is_meta;
    wire [LANES-1:0] type_ok;
    wire [LANES-1:0] is_sync;
    wire [LANES-1:0] is_diag;
    wire [LANES-1:0] wr_valid;
    wire [LANES-1:0] pop;
    wire [LANES*BW-1:0] head;
    wire [MUW-1:0] mu_rx;
    wire mu_load;

    assign o_raw_rx_lane0_word = out_word_r[0*WW +: WW];
    assign o_raw_rx_lane1_word = out_word_r[1*WW +: WW];
    assign o_raw_rx_lane2_word = out_word_r[2*WW +: WW];
    assign o_raw_rx_lane3_word = out_word_r[3*WW +: WW];
    assign o_raw_rx_lane4_word = out_word_r[4*WW +: WW];
    assign o_raw_rx_lane5_word = out_word_r[5*WW +: WW];
    assign o_raw_rx_lane6_word = out_word_r[6*WW +: WW];
    assign o_raw_rx_lane7_word = out_word_r[7*WW +: WW];
    assign o_raw_rx_lane8_word = out_word_r[8*WW +: WW];
    assign o_raw_rx_lane9_word = out_word_r[9*WW +: WW];
    assign o_raw_rx_lane10_word = out_word_r[10*WW +: WW];
    assign o_raw_rx_lane11_word = out_word_r[11*WW +: WW];

    ////////////////////////////////////////////////////////////////////////
    // per-lane decode, word lock and buffer

    genvar l;
    generate
        for (l = 0; l < LANES; l = l + 1)
        begin : g_lane
            wire [WW-1:0] w;
            wire [1:0] frm;
            wire [5:0] btype;
            wire is_ctl;
            reg [CW-1:0] cnt_r;
            reg [CW-1:0] cnt_nxt;
            reg lock_nxt;

            assign w = i_rx_lane_word[l*WW +: WW];
            assign frm = w[`RLSB_FRM_MSB:`RLSB_FRM_LSB];
            assign btype = w[`RLSB_TYPE_MSB:`RLSB_TYPE_LSB];
            assign frm_ok[l] = (frm == `RLSB_FRM_DATA) | (frm == `RLSB_FRM_CTRL);
            assign is_ctl = (frm == `RLSB_FRM_CTRL);
            assign is_meta[l] = is_ctl & ~w[`RLSB_META_BIT];
            assign type_ok[l] = (btype == `RLSB_TYPE_SYNC)
                | (btype == `RLSB_TYPE_SCRAM)
                | (btype == `RLSB_TYPE_SKIP)
                | (btype == `RLSB_TYPE_DIAG);
            assign is_sync[l] = is_meta[l] & (btype == `RLSB_TYPE_SYNC);
            assign is_diag[l] = is_meta[l] & (btype == `RLSB_TYPE_DIAG);

            // lock depends on framing bits only, never on meta word content
            always @*
            begin
                cnt_nxt = cnt_r;
                lock_nxt = o_rx_word_lock[l];
                if (i_raw_rx_force_resync)
                begin
                    cnt_nxt = {CW{1'b0}};
                    lock_nxt = 1'b0;
                end
                else if (i_rx_lane_word_valid[l] & o_rx_lane_word_ready[l])
                begin
                    if (!frm_ok[l])
                    begin
                        cnt_nxt = {CW{1'b0}};
                        lock_nxt = 1'b0;
                    end
                    else if (!o_rx_word_lock[l])
                    begin
                        if (cnt_r == `RLSB_LOCK_CNT - 1'b1)
                        begin
                            cnt_nxt = {CW{1'b0}};
                            lock_nxt = 1'b1;
                        end
                        else
                            cnt_nxt = cnt_r + 1'b1;
                    end
                end
            end

            always @(posedge i_clk_sys or posedge i_rst)
            begin
                if (i_rst)
                begin
                    cnt_r <= {CW{1'b0}};
                    o_rx_word_lock[l] <= 1'b0;
                    o_rx_bad_type_err[l] <= 1'b0;
                end
                else
                begin
                    cnt_r <= cnt_nxt;
                    o_rx_word_lock[l] <= lock_nxt;
                    o_rx_bad_type_err[l] <= wr_valid[l] & o_rx_lane_word_ready[l]
                        & is_meta[l] & ~type_ok[l];
                end
            end

            // only words seen under lock enter the buffer
            assign wr_valid[l] = i_rx_lane_word_valid[l] & o_rx_word_lock[l]
                & ~i_raw_rx_force_resync;

            rlsb_fifo #(
                .W(BW),
                .D(DEPTH),
                .AW(AW)
            ) u_buf (
                .i_clk_sys(i_clk_sys),
                .i_rst(i_rst),
                .i_flush(i_raw_rx_force_resync),
                .i_in_valid(wr_valid[l]),
                .o_in_ready(o_rx_lane_word_ready[l]),
                .i_in_data({~frm_ok[l] & ~is_meta[l], is_sync[l], w}),
                .o_out_valid(o_raw_rx_lane_word_available[l]),
                .i_out_ready(pop[l]),
                .o_out_data(head[l*BW +: BW])
            );

            // is relied on: a lane without a word simply is not popped
            assign pop[l] = i_raw_rx_read_request & o_raw_rx_lane_word_available[l];

            always @(posedge i_clk_sys or posedge i_rst)
            begin
                if (i_rst)
                begin
                    out_word_r[l*WW +: WW] <= {WW{1'b0}};
                    o_raw_rx_lane_word_valid[l] <= 1'b0;
                    o_raw_rx_framing_word_flag[l] <= 1'b0;
                    o_raw_rx_bad_framing_flag[l] <= 1'b0;
                end
                else
                begin
                    o_raw_rx_lane_word_valid[l] <= pop[l];
                    if (pop[l])
                    begin
                        out_word_r[l*WW +: WW] <= head[l*BW +: WW];
                        o_raw_rx_framing_word_flag[l] <= head[l*BW + WW];
                        o_raw_rx_bad_framing_flag[l] <= head[l*BW + WW + 1];
                    end
                    else
                    begin
                        o_raw_rx_framing_word_flag[l] <= 1'b0;
                        o_raw_rx_bad_framing_flag[l] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // multi-use bits from lane 0 diagnostic words

    assign mu_rx = i_rx_lane_word[`RLSB_MU_LSB +: MUW];
    assign mu_load = wr_valid[0] & o_rx_lane_word_ready[0] & is_diag[0];

    always @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_rx_multiuse_control_bits <= `RLSB_MU_RST;
            o_rx_multiuse_bits_changed_pulse <= 1'b0;
        end
        else
        begin
            o_rx_multiuse_bits_changed_pulse <= 1'b0;
            if (mu_load && (mu_rx != o_rx_multiuse_control_bits))
            begin
                o_rx_multiuse_control_bits <= mu_rx;
                o_rx_multiuse_bits_changed_pulse <= 1'b1;
            end
        end
    end
endmodule // rlsb_rx_lane_status
`default_nettype wire

// >>> rtl/rlsb_map.vh
// Purpose: constants for the receive lane status and raw read block
// Assumes: 66-bit lane words, framing in bits 65:64, block type in 63:58
// Notes: included by the lane status design file only; rlsb_fifo does not include it
`ifndef RLSB_MAP_VH
`define RLSB_MAP_VH

`define RLSB_LANES 12
`define RLSB_WORD_W 66
`define RLSB_FIFO_DEPTH 8
`define RLSB_FIFO_AW 3

// framing field and its legal codes
`define RLSB_FRM_MSB 65
`define RLSB_FRM_LSB 64
`define RLSB_FRM_DATA 2'h1
`define RLSB_FRM_CTRL 2'h2

// control word layout: bit 63 low marks a meta frame word
`define RLSB_META_BIT 63
`define RLSB_TYPE_MSB 63
`define RLSB_TYPE_LSB 58
`define RLSB_TYPE_SYNC 6'h1E
`define RLSB_TYPE_SCRAM 6'h1A
`define RLSB_TYPE_SKIP 6'h19
`define RLSB_TYPE_DIAG 6'h18

// word lock
`define RLSB_LOCK_CNT 7'h40
`define RLSB_LOCK_CW 7

// multi-use bits carried in lane 0 diagnostic words
`define RLSB_MU_LSB 32
`define RLSB_MU_W 8
`define RLSB_MU_RST 8'h00

`endif

// >>> rtl/rlsb_fifo.v
// Purpose: one lane word buffer with valid/ready on both sides
// Assumes: single clock, synchronous flush
// Notes: show-ahead; o_out_data is the head word whenever o_out_valid
`timescale 1ns/1ps
`default_nettype none
module rlsb_fifo #(
    parameter W = 68,
    parameter D = 8,
    parameter AW = 3
) (
    input wire i_clk_sys,
    input wire i_rst,
    input wire i_flush,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [W-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [W-1:0] o_out_data
);
    reg [W-1:0] mem_r [0:D-1];
    reg [AW-1:0] wr_r;
    reg [AW-1:0] rd_r;
    reg [AW:0] cnt_r;
    wire push;
    wire pop;

    assign o_in_ready = (cnt_r != D[AW:0]);
    assign o_out_valid = (cnt_r != {(AW+1){1'b0}});
    assign o_out_data = mem_r[rd_r];
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;

    always @(posedge i_clk_sys)
    begin
        if (push)
            mem_r[wr_r] <= i_in_data;
    end

    always @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            wr_r <= {AW{1'b0}};
            rd_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end
        else if (i_flush)
        begin
            wr_r <= {AW{1'b0}};
            rd_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_r <= (wr_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
            if (pop)
                rd_r <= (rd_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
            if (push & ~pop)
                cnt_r <= cnt_r + 1'b1;
            else if (pop & ~push)
                cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule // rlsb_fifo
`default_nettype wire

// >>> verif/rlsb_rx_asserts.sv
// Purpose: concurrent checks on lane status and raw read ports
// Assumes: one clock, asynchronous active-high reset
// Notes: lock counting is watched on lane 0 only
`timescale 1ns/1ps
`default_nettype none
module rlsb_rx_asserts #(parameter LANES = 12, parameter WW = 66, parameter MUW = 8) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [LANES*WW-1:0] i_rx_lane_word,
    input wire logic [LANES-1:0] i_rx_lane_word_valid,
    input wire logic [LANES-1:0] o_rx_lane_word_ready,
    input wire logic [LANES-1:0] o_rx_bad_type_err,
    input wire logic [LANES-1:0] o_rx_word_lock,
    input wire logic [MUW-1:0] o_rx_multiuse_control_bits,
    input wire logic o_rx_multiuse_bits_changed_pulse,
    input wire logic i_raw_rx_read_request,
    input wire logic i_raw_rx_force_resync,
    input wire logic [LANES-1:0] o_raw_rx_lane_word_available,
    input wire logic [LANES-1:0] o_raw_rx_lane_word_valid,
    input wire logic [LANES-1:0] o_raw_rx_framing_word_flag,
    input wire logic [LANES-1:0] o_raw_rx_bad_framing_flag
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    logic [6:0] cnt0_r;
    wire take0 = i_rx_lane_word_valid[0] & o_rx_lane_word_ready[0];
    wire [1:0] frm0 = i_rx_lane_word[65:64];
    // run of well-framed words taken on lane 0
    always_ff @(posedge i_clk_sys or posedge i_rst)
        if (i_rst)
            cnt0_r <= 7'h00;
        else if (i_raw_rx_force_resync || (take0 && (frm0 == 2'h0 || frm0 == 2'h3)))
            cnt0_r <= 7'h00;
        else if (take0 && cnt0_r != 7'h7F)
            cnt0_r <= cnt0_r + 7'h01;
    ////////////////////////////////////////
    sequence s_cleared;
        o_rx_word_lock == '0 && o_raw_rx_lane_word_available == '0;
    endsequence
    sequence s_popped;
        o_raw_rx_lane_word_valid == $past(o_raw_rx_lane_word_available);
    endsequence
    a_mu_pulse_change: assert property (
        $changed(o_rx_multiuse_control_bits) == o_rx_multiuse_bits_changed_pulse)
        else $error("multiuse pulse does not match a change");
    a_lock_after_64: assert property ($rose(o_rx_word_lock[0]) |-> cnt0_r >= 7'h40)
        else $error("lock before 64 framed words");
    a_lock_loss_cause: assert property ($fell(o_rx_word_lock[0]) |-> cnt0_r == 7'h00)
        else $error("lock dropped without cause");
    a_resync_clears: assert property (i_raw_rx_force_resync |=> s_cleared)
        else $error("resync did not clear lock and buffers");
    a_read_pops_avail: assert property (
        i_raw_rx_read_request && !i_raw_rx_force_resync |=> s_popped)
        else $error("read did not pop the available lanes");
    a_no_read_idle: assert property (!i_raw_rx_read_request |=> o_raw_rx_lane_word_valid == '0)
        else $error("word valid without read");
    a_flags_need_valid: assert property (
        ((o_raw_rx_framing_word_flag | o_raw_rx_bad_framing_flag) & ~o_raw_rx_lane_word_valid) == '0)
        else $error("word flag without valid");
    a_flags_exclusive: assert property (
        (o_raw_rx_framing_word_flag & o_raw_rx_bad_framing_flag) == '0)
        else $error("sync word flagged badly framed");
    a_bad_type_locked: assert property ((o_rx_bad_type_err & ~$past(o_rx_word_lock)) == '0)
        else $error("type error on unlocked lane");
endmodule // rlsb_rx_asserts
bind rlsb_rx_lane_status rlsb_rx_asserts #(.LANES(LANES), .WW(WW), .MUW(MUW)) u_asserts (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_rx_lane_word(i_rx_lane_word),
    .i_rx_lane_word_valid(i_rx_lane_word_valid),
    .o_rx_lane_word_ready(o_rx_lane_word_ready),
    .o_rx_bad_type_err(o_rx_bad_type_err),
    .o_rx_word_lock(o_rx_word_lock),
    .o_rx_multiuse_control_bits(o_rx_multiuse_control_bits),
    .o_rx_multiuse_bits_changed_pulse(o_rx_multiuse_bits_changed_pulse),
    .i_raw_rx_read_request(i_raw_rx_read_request),
    .i_raw_rx_force_resync(i_raw_rx_force_resync),
    .o_raw_rx_lane_word_available(o_raw_rx_lane_word_available),
    .o_raw_rx_lane_word_valid(o_raw_rx_lane_word_valid),
    .o_raw_rx_framing_word_flag(o_raw_rx_framing_word_flag),
    .o_raw_rx_bad_framing_flag(o_raw_rx_bad_framing_flag)
);
`default_nettype wire

// >>> verif/rlsb_user_model.sv
// Purpose: user-side consumer of raw lane words
// Assumes: requests only while some lane shows a word
// Notes: slow mode requests every other cycle to stall the drain
`timescale 1ns/1ps
`default_nettype none
module rlsb_user_model (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_en,
    input wire logic i_slow,
    input wire logic [11:0] i_avail,
    output logic o_read
);
    logic skip_r;
    always @(posedge i_clk_sys or posedge i_rst)
        if (i_rst)
            skip_r <= 1'b0;
        else
            skip_r <= i_slow & ~skip_r;
    assign o_read = i_en & (|i_avail) & ~skip_r;
endmodule // rlsb_user_model
`default_nettype wire

// >>> verif/tb_rx_lane_status_bypass_read.sv
// Purpose: self-checking bench for lane status and raw read port
// Assumes: 125 MHz clock, inputs driven 1 ns after each rising edge
// Notes: table rows cover the meta word kinds on lane 0
`timescale 1ns/1ps
`default_nettype none
module tb_rx_lane_status_bypass_read;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic [791:0] lw = '0;
    logic [11:0] lv = '0;
    logic en = 1'b0, slow = 1'b0, rs = 1'b0;
    logic [7:0] emu = 8'h00;
    wire rd, mup;
    wire [11:0] rdy, err, lock, av, vld, syn, bad;
    wire [7:0] mu;
    wire [65:0] w0, w11;
    int n_fail = 0, total_checks = 0, errs = 0, syns = 0, pulses = 0;
    logic [16:0] rows [7] = '{{6'h1E, 8'h00, 3'h2}, {6'h1A, 8'h00, 3'h0}, {6'h19, 8'h00, 3'h0},
        {6'h18, 8'h5A, 3'h1}, {6'h18, 8'h5A, 3'h0}, {6'h11, 8'h00, 3'h4}, {6'h18, 8'h00, 3'h1}};
    always #4 i_clk_sys = ~i_clk_sys;
    rlsb_rx_lane_status uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_rx_lane_word(lw),
        .i_rx_lane_word_valid(lv), .o_rx_lane_word_ready(rdy), .o_rx_bad_type_err(err),
        .o_rx_word_lock(lock), .o_rx_multiuse_control_bits(mu),
        .o_rx_multiuse_bits_changed_pulse(mup), .i_raw_rx_read_request(rd),
        .i_raw_rx_force_resync(rs), .o_raw_rx_lane_word_available(av),
        .o_raw_rx_lane_word_valid(vld), .o_raw_rx_framing_word_flag(syn),
        .o_raw_rx_bad_framing_flag(bad), .o_raw_rx_lane0_word(w0), .o_raw_rx_lane1_word(),
        .o_raw_rx_lane2_word(), .o_raw_rx_lane3_word(), .o_raw_rx_lane4_word(),
        .o_raw_rx_lane5_word(), .o_raw_rx_lane6_word(), .o_raw_rx_lane7_word(),
        .o_raw_rx_lane8_word(), .o_raw_rx_lane9_word(), .o_raw_rx_lane10_word(),
        .o_raw_rx_lane11_word(w11));
    rlsb_user_model u_user (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_en(en), .i_slow(slow),
        .i_avail(av), .o_read(rd));
    ////////////////////////////////////////
    always @(posedge i_clk_sys)
    begin
        errs += err[0];
        pulses += mup;
        syns += vld[0] & syn[0];
    end
    task automatic chk(input logic [65:0] got, input logic [65:0] exp, input string m);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    function automatic logic [65:0] dw(input int l, input int i);
        return {2'h1, 8'(l), 56'(i)};
    endfunction
    function automatic logic [65:0] mw(input logic [5:0] t, input logic [7:0] m);
        return {2'h2, t, 18'h0, m, 32'h0};
    endfunction
    // one word on every lane; lane badl gets a broken framing field
    task automatic send_all(input int i, input int badl);
        for (int l = 0; l < 12; l++)
            lw[l*66 +: 66] = (l == badl) ? 66'h0 : dw(l, i);
        lv = 12'hFFF;
        tick(1);
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        int q;
        tick(6);
        i_rst = 1'b0;
        tick(1);
        chk(rdy, 12'hFFF, "ready after reset");
        chk(lock | av, 12'h000, "idle after reset");
        $display("reset test done");
        for (int i = 0; i < 64; i++)
            send_all(i, (i == 10) ? 5 : 99);
        chk(lock, 12'hFDF, "lock at 64th word");
        for (int i = 64; i < 75; i++)
            send_all(i, 99);
        lv = '0;
        tick(1);
        chk(lock, 12'hFFF, "lane 5 lock after restart");
        chk(rdy, 12'h020, "full buffers refuse");
        chk(av, 12'hFDF, "words available");
        $display("lock test done");
        slow = 1'b1;
        en = 1'b1;
        q = 0;
        for (int k = 0; k < 40 && q < 8; k++)
        begin
            tick(1);
            if (vld[0])
            begin
                chk(w0, dw(0, 64 + q), "drained word order");
                chk(w11, dw(11, 64 + q), "lane 11 word order");
                chk(vld, 12'hFDF, "locked lanes popped together");
                q++;
            end
        end
        chk(q, 8, "drain count");
        chk(av, 12'h000, "drained empty");
        slow = 1'b0;
        $display("drain test done");
        foreach (rows[r])
        begin
            errs = 0;
            syns = 0;
            pulses = 0;
            lw[65:0] = mw(rows[r][16:11], rows[r][10:3]);
            if (rows[r][16:11] == 6'h18)
                emu = rows[r][10:3];
            lv = 12'h001;
            tick(1);
            lv = '0;
            tick(4);
            chk(errs, rows[r][2], "bad type flag");
            chk(syns, rows[r][1], "sync word flag");
            chk(pulses, rows[r][0], "multiuse pulse");
            chk(mu, emu, "multiuse bits");
            chk(w0, lw[65:0], "meta word passed");
        end
        $display("meta row test done");
        lw[65:64] = 2'h3;
        lv = 12'h001;
        tick(1);
        lv = '0;
        tick(1);
        chk(lock, 12'hFFE, "lock lost on bad framing");
        chk({bad, syn, vld}, {12'h001, 12'h000, 12'h001}, "bad framing word read");
        en = 1'b0;
        for (int i = 0; i < 3; i++)
            send_all(i, 99);
        lv = '0;
        tick(1);
        chk(av, 12'hFFE, "words before resync");
        rs = 1'b1;
        tick(1);
        rs = 1'b0;
        tick(1);
        chk(lock | av, 12'h000, "resync clears");
        $display("resync test done");
        conclude();
    end
endmodule // tb_rx_lane_status_bypass_read
`default_nettype wire
